// file: gpc_pkg.sv
package gpc_pkg;
   // Pin count of the group and field layouts
   localparam int NPIN = 8;
   localparam int NGRP = 13;
   localparam int GRP_IDX = 0;
   localparam logic [15:0] ZERO16 = 16'h0000;
   // Register byte offsets on the bus
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_IOEN = 8'h04;
   localparam logic [7:0] OFF_PULL = 8'h08;
   localparam logic [7:0] OFF_FLAG = 8'h0c;
   localparam logic [7:0] OFF_ECTL = 8'h10;
   localparam logic [7:0] OFF_DBEN = 8'h14;
   localparam logic [7:0] OFF_MODE = 8'h18;
   localparam logic [7:0] OFF_FSEL = 8'h1c;
   localparam logic [7:0] OFF_FCLK = 8'h20;
   localparam logic [7:0] OFF_GRP = 8'h24;
   // Filter clock control fields
   localparam int FC_SRC_LO = 0;
   localparam int FC_KRST_LO = 2;
   localparam int FC_DIV_LO = 4;
   localparam int FC_DBG_BIT = 8;
   localparam logic [15:0] FC_MASK = 16'h01ff;
   localparam logic [1:0] KRST_OFF = 2'h0;
   localparam logic [1:0] KRST_P1 = 2'h1;
   localparam logic [1:0] KRST_P2 = 2'h2;
   localparam logic [1:0] KRST_P3 = 2'h3;
   // Debounce: the level must hold this many filter ticks
   localparam logic [1:0] DB_TICKS = 2'h2;
   // Per-pin pad controls
   typedef struct packed {
      logic [NPIN-1:0] out;
      logic [NPIN-1:0] oe_n;
      logic [NPIN-1:0] pull_en;
      logic [NPIN-1:0] pull_up;
   } gpc_pad_type;
   // Peripheral side of the pins
   typedef struct packed {
      logic [NPIN-1:0] out;
      logic [NPIN-1:0] oe;
   } gpc_peri_type;
endpackage

// file: gpc_port.sv
`timescale 1ns/1ps
// How it works
// - Output enable 1 drives stored output value; writes while disabled only stored.
// - Peripheral-owned pin ignores GPIO output value and enable.
// - Input value reads the pin only while input gate is 1, else 0.
// - Peripheral-owned pin reads 0 in the input value bits.
// - With input and output enabled, input reads the driven level.
// - Output enable 0 leaves the pin high impedance.
// - Pull direction 1 selects up, 0 down; applied only with pull enable.
// - No pull while output enable is 1.
// - Peripheral-owned pin ignores GPIO input, output and pull settings.
// - Edge flag reads 1 after an event; write 1 clears, 0 keeps.
// - Edge polarity 1 catches falling edges, 0 rising edges.
// - Debounce enable routes the edge and key reset input through the filter, else bypass; the input value bits always read unfiltered.
// - Function mode 1 hands the pin to a peripheral; reset value 0.
// - Function choice 0..3 picks the peripheral function; peri_fn carries it whatever the function mode.
// - Run-in-debug bit 8 keeps the filter clock running while halted.
// - Key reset off at 0, else requests reset when pins 1:0/2:0/3:0 all low.
// - Filter clock source code selects one of four clock sources.
// - Divider code 0..f divides the source by 1 up to 32768.
// - Group summary register holds one read-only bit per group, bits 12..0.
// - Interrupt request only when flag set and its enable is 1.
// - Summary bit not set by flags of disabled pins.
// - Summary bit clears once those flags are cleared.
// - Debounce drops pulses shorter than two to three filter ticks.
module gpc_port
   import gpc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and peripherals
   input wire logic [gpc_pkg::NPIN-1:0] pin_in,
   input wire gpc_pkg::gpc_peri_type peri_in,
   output gpc_pkg::gpc_pad_type pad,
   output logic [gpc_pkg::NPIN-1:0] peri_rx,
   output logic [1:0] peri_fn [gpc_pkg::NPIN],
   // Filter clock sources, one-cycle ticks
   input wire logic [3:0] src_tick,
   input wire logic debug_mode,
   // Interrupt and reset requests
   output logic irq,
   output logic key_reset_req
);
   import gpc_pkg::*;

   logic [NPIN-1:0] out_r, ien_r, oen_r, pdir_r, pen_r, flag_r, edge_r, ie_r;
   logic [NPIN-1:0] dben_r, mode_r;
   logic [15:0] fsel_r;
   logic [15:0] fclk_r;
   logic [NPIN-1:0] sync1_r, sync2_r, filt_r, prev_r;
   logic [1:0] dbcnt_r [NPIN];
   logic [14:0] div_r;
   logic tick_r;
   logic [NGRP-1:0] grp_r;

   // Read word of a register that holds two pin fields, upper field first
   function automatic logic [15:0] gpc_rd(input logic [7:0] hi, input logic [7:0] lo);
      gpc_rd = {hi, lo};
   endfunction

   // Write strobe of one register offset in the access cycle
   function automatic logic gpc_wr_hit(input logic w, input logic [7:0] a,
         input logic [7:0] off);
      gpc_wr_hit = w && (a == off);
   endfunction

   // Ones in the low n bits of the divider; n = 0 gives none, so every tick passes
   function automatic logic [14:0] gpc_low_mask(input logic [3:0] n);
      gpc_low_mask = (15'h1 << n) - 15'h1;
   endfunction

   // A pin that is both flagged and enabled asks for service
   function automatic logic gpc_any_pending(input logic [NPIN-1:0] flags,
         input logic [NPIN-1:0] en);
      gpc_any_pending = |(flags & en);
   endfunction

   logic acc, wr;
   assign acc = psel && penable && clk_en;
   assign wr = acc && pwrite;

   // Fields of the shared filter clock control word
   logic [1:0] fsrc, krst;
   logic [3:0] fdiv;
   assign fsrc = fclk_r[FC_SRC_LO +: 2];
   assign krst = fclk_r[FC_KRST_LO +: 2];
   assign fdiv = fclk_r[FC_DIV_LO +: 4];

   // Pin-facing inputs: GPIO sees nothing of a peripheral pin
   logic [NPIN-1:0] gpio_own, drv_gpio, in_sel, qual, edge_hit, in_level;
   assign gpio_own = ~mode_r;
   assign drv_gpio = oen_r & gpio_own;
   // Driving GPIO pins with the input gate on read back their own level, as the pad loops it
   assign in_sel = ien_r & gpio_own;

   // One strobe per writable register, decoded once and shared by the blocks below
   // Strobes carry clk_en through wr, so a frozen block ignores the bus
   logic wr_data, wr_ioen, wr_pull, wr_flag, wr_ectl, wr_dben, wr_mode, wr_fsel, wr_fclk;
   assign wr_data = gpc_wr_hit(wr, paddr, OFF_DATA);
   assign wr_ioen = gpc_wr_hit(wr, paddr, OFF_IOEN);
   assign wr_pull = gpc_wr_hit(wr, paddr, OFF_PULL);
   assign wr_flag = gpc_wr_hit(wr, paddr, OFF_FLAG);
   assign wr_ectl = gpc_wr_hit(wr, paddr, OFF_ECTL);
   assign wr_dben = gpc_wr_hit(wr, paddr, OFF_DBEN);
   assign wr_mode = gpc_wr_hit(wr, paddr, OFF_MODE);
   assign wr_fsel = gpc_wr_hit(wr, paddr, OFF_FSEL);
   assign wr_fclk = gpc_wr_hit(wr, paddr, OFF_FCLK);
   // The summary offset has no strobe: software cannot write it

   // Stored output value; written even while the pin is not driven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r <= '0;
      end else if (wr_data) begin
         out_r <= pwdata[15:8];
      end
   end

   // Input and output gates of each pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_r <= '0;
         oen_r <= '0;
      end else if (wr_ioen) begin
         ien_r <= pwdata[15:8];
         oen_r <= pwdata[7:0];
      end
   end

   // Pull direction and pull enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdir_r <= '0;
         pen_r <= '0;
      end else if (wr_pull) begin
         pdir_r <= pwdata[15:8];
         pen_r <= pwdata[7:0];
      end
   end

   // Edge polarity and interrupt enable of each pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_r <= '0;
         ie_r <= '0;
      end else if (wr_ectl) begin
         edge_r <= pwdata[15:8];
         ie_r <= pwdata[7:0];
      end
   end

   // Debounce enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dben_r <= '0;
      end else if (wr_dben) begin
         dben_r <= pwdata[7:0];
      end
   end

   // Function mode; a set bit hands the pin to its peripheral
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= '0;
      end else if (wr_mode) begin
         mode_r <= pwdata[7:0];
      end
   end

   // Function choice, two bits a pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsel_r <= ZERO16;
      end else if (wr_fsel) begin
         fsel_r <= pwdata[15:0];
      end
   end

   // Filter clock control; the reserved upper bits stay zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fclk_r <= ZERO16;
      end else if (wr_fclk) begin
         fclk_r <= pwdata[15:0] & FC_MASK;
      end
   end

   // Two-stage synchroniser; only the second stage feeds logic
   // The first stage may settle late, so nothing else may read it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else if (clk_en) begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
      end
   end

   // Filter clock: source pick, then power-of-two divider
   // Halted in debug unless run-in-debug is set
   logic src_on, div_hit;
   assign src_on = src_tick[fsrc] && !(debug_mode && !fclk_r[FC_DBG_BIT]);
   // Hits when the low fdiv bits are all ones, so one tick in 2^fdiv passes
   assign div_hit = (div_r & gpc_low_mask(fdiv)) == gpc_low_mask(fdiv);
   // Divider counts source ticks only; a stopped source or a halt freezes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= '0;
      end else if (clk_en && src_on) begin
         div_r <= div_hit ? '0 : div_r + 15'h1;
      end
   end

   // Filter tick, one pclk cycle wide, for the debounce samplers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_r <= 1'b0;
      end else if (clk_en) begin
         tick_r <= src_on && div_hit;
      end
   end

   // Debounce: accept a new level after it holds for DB_TICKS+1 samples
   // Samples only on filter ticks; a pulse near the limit may pass or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_r <= '0;
         for (int i = 0; i < NPIN; i++) begin
            dbcnt_r[i] <= '0;
         end
      end else if (clk_en && tick_r) begin
         for (int i = 0; i < NPIN; i++) begin
            if (sync2_r[i] == filt_r[i]) begin
               dbcnt_r[i] <= '0;
            end else if (dbcnt_r[i] == DB_TICKS) begin
               filt_r[i] <= sync2_r[i];
               dbcnt_r[i] <= '0;
            end else begin
               dbcnt_r[i] <= dbcnt_r[i] + 2'h1;
            end
         end
      end
   end

   assign in_level = (dben_r & filt_r) | (~dben_r & sync2_r);
   // A disabled input counts as a steady 0, so a floating pin raises no flag
   // and a peripheral pin never reaches the edge logic
   assign qual = in_level & in_sel;

   // Edge detector per pin
   // Both sides start at 0 after reset, so no false edge follows it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= '0;
      end else if (clk_en) begin
         prev_r <= qual;
      end
   end
   assign edge_hit = (edge_r & prev_r & ~qual) | (~edge_r & ~prev_r & qual);

   // Edge flags: a new event wins over a clearing write
   // Writing 0 to a bit keeps that flag, so software may clear one pin alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= '0;
      end else if (clk_en) begin
         flag_r <= (flag_r & ~(wr_flag ? pwdata[7:0] : 8'h00)) | edge_hit;
      end
   end

   // Group summary from enabled flags only
   // One group lives in this block; its bit sits at GRP_IDX, the others read 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grp_r <= '0;
      end else if (clk_en) begin
         grp_r <= '0;
         grp_r[GRP_IDX] <= gpc_any_pending(flag_r, ie_r);
      end
   end

   // Interrupt request to the controller
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= gpc_any_pending(flag_r, ie_r);
      end
   end

   // Key reset: selected low pins all low
   // Uses the debounced level where enabled, so a short press does not reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_reset_req <= 1'b0;
      end else if (clk_en) begin
         case (krst)
            KRST_P1: key_reset_req <= ~|in_level[1:0];
            KRST_P2: key_reset_req <= ~|in_level[2:0];
            KRST_P3: key_reset_req <= ~|in_level[3:0];
            default: key_reset_req <= 1'b0;
         endcase
      end
   end

   // Pad drive: GPIO or peripheral owns each pin
   // Registered so the pad sees no decode glitches; costs one cycle of latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad <= '{out: '0, oe_n: '1, pull_en: '0, pull_up: '0};
      end else if (clk_en) begin
         pad.out <= (mode_r & peri_in.out) | (gpio_own & out_r);
         pad.oe_n <= ~((mode_r & peri_in.oe) | drv_gpio);
         pad.pull_en <= gpio_own & pen_r & ~oen_r;
         pad.pull_up <= pdir_r;
      end
   end

   // Peripheral side: synchronised input and the function choice of each pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peri_rx <= '0;
         for (int i = 0; i < NPIN; i++) begin
            peri_fn[i] <= 2'h0;
         end
      end else if (clk_en) begin
         peri_rx <= sync2_r & mode_r;
         for (int i = 0; i < NPIN; i++) begin
            peri_fn[i] <= fsel_r[2*i +: 2];
         end
      end
   end

   // APB read data and completion; zero wait states, unmapped reads 0
   // Data is caught in setup so it stands through the whole access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               OFF_DATA: prdata <= {16'h0, gpc_rd(out_r, sync2_r & in_sel)};
               OFF_IOEN: prdata <= {16'h0, gpc_rd(ien_r, oen_r)};
               OFF_PULL: prdata <= {16'h0, gpc_rd(pdir_r, pen_r)};
               OFF_FLAG: prdata <= {16'h0, gpc_rd(8'h00, flag_r)};
               OFF_ECTL: prdata <= {16'h0, gpc_rd(edge_r, ie_r)};
               OFF_DBEN: prdata <= {16'h0, gpc_rd(8'h00, dben_r)};
               OFF_MODE: prdata <= {16'h0, gpc_rd(8'h00, mode_r)};
               OFF_FSEL: prdata <= {16'h0, fsel_r};
               OFF_FCLK: prdata <= {16'h0, fclk_r};
               OFF_GRP: prdata <= {19'h0, grp_r};
               default: prdata <= '0;
            endcase
         end
      end
   end
endmodule // gpc_port

// file: gpc_port_props.sv
`timescale 1ns/1ps
// Watches the bus handshake and the pad controls at the ports
module gpc_port_props
   import gpc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins, peripheral and requests
   input wire logic [gpc_pkg::NPIN-1:0] pin_in,
   input wire gpc_pkg::gpc_peri_type peri_in,
   input wire gpc_pkg::gpc_pad_type pad,
   input wire logic [gpc_pkg::NPIN-1:0] peri_rx,
   input wire logic [1:0] peri_fn [gpc_pkg::NPIN],
   input wire logic [3:0] src_tick,
   input wire logic debug_mode,
   input wire logic irq,
   input wire logic key_reset_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Read setup; prdata may only move in the cycle after it
   logic rd_setup;
   assign rd_setup = psel && !penable && !pwrite && clk_en;
   chk_ready_access: assert property (psel && !penable && clk_en |=> pready)
      else $error("pready missing in access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held two cycles");
   chk_no_slverr: assert property (!pslverr)
      else $error("pslverr raised");
   chk_read_stands: assert property (!rd_setup |=> $stable(prdata))
      else $error("prdata moved outside a read");
   chk_upper_zero: assert property (rd_setup |=> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   chk_group_bits: assert property (rd_setup && paddr == OFF_GRP |=> prdata[15:1] == 15'h0000)
      else $error("summary reserved bits set");
   chk_unmapped_zero: assert property (rd_setup && paddr > OFF_GRP |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_no_pull_drive: assert property ((~pad.oe_n & pad.pull_en) == 8'h00)
      else $error("pull applied on a driven pin");
endmodule // gpc_port_props
bind gpc_port gpc_port_props gpc_port_props_i (.*);

// file: gpc_pin_model.sv
`timescale 1ns/1ps
// Board around the pins: own drive, outside drive, pulls, else floating
module gpc_pin_model
   import gpc_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Pad side
   input wire gpc_pkg::gpc_pad_type pad,
   output logic [gpc_pkg::NPIN-1:0] pin_in,
   // Outside drivers
   input wire logic [gpc_pkg::NPIN-1:0] ext_en,
   input wire logic [gpc_pkg::NPIN-1:0] ext_val
);
   logic flt_r = 1'b0;
   // Toggles so a floating pin never looks like a steady level
   always_ff @(posedge pclk) begin
      flt_r <= ~flt_r;
   end
   // Pad drive wins over outside drive, which wins over the pull
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (!pad.oe_n[i]) pin_in[i] = pad.out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pad.pull_en[i]) pin_in[i] = pad.pull_up[i];
         else pin_in[i] = flt_r ^ i[0];
      end
   end
endmodule // gpc_pin_model

// file: test_gpc_port.sv
`timescale 1ns/1ps
// Self-checking bench for the port control block
module test_gpc_port;
   import gpc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, irq, key_reset_req;
   logic [NPIN-1:0] pin_in, peri_rx, ext_en = 8'h00, ext_val = 8'h00;
   gpc_peri_type peri_in = 16'h0000;
   gpc_pad_type pad;
   logic [1:0] peri_fn [NPIN];
   logic [3:0] src_tick = 4'h0;
   logic [1:0] tdiv = 2'h0;
   logic debug_mode = 1'b0;
   int mismatches = 0, checks_done = 0;
   gpc_port gpc_port_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .peri_in(peri_in), .pad(pad),
      .peri_rx(peri_rx), .peri_fn(peri_fn), .src_tick(src_tick), .debug_mode(debug_mode),
      .irq(irq), .key_reset_req(key_reset_req));
   gpc_pin_model gpc_pin_model_i (.pclk(pclk), .pad(pad), .pin_in(pin_in),
      .ext_en(ext_en), .ext_val(ext_val));
   initial forever #2.5 pclk = ~pclk;
   // Filter sources tick every fourth cycle
   always @(posedge pclk) begin
      tdiv <= tdiv + 2'h1;
      src_tick <= {4{tdiv == 2'h3}};
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; waits for pready, a hung wait is ended by the watchdog
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 16'h0000);
      chk(rdat, e);
   endtask
   task automatic t_regs();
      for (int i = 0; i < 11; i++) rd(8'(4 * i), 32'h0);
      chk(32'(pad.oe_n), 32'hff);
      apb(1'b1, OFF_GRP, 16'hffff);
      rd(OFF_GRP, 32'h0);
   endtask
   // Stored output shows only on enabled pins; with input on it reads back
   task automatic t_out();
      ext_en <= 8'hf0;
      ext_val <= 8'h30;
      apb(1'b1, OFF_IOEN, 16'h000f);
      apb(1'b1, OFF_DATA, 16'ha500);
      rd(OFF_DATA, 32'ha500);
      chk(32'({pad.oe_n, pad.out[3:0]}), 32'hf05);
      apb(1'b1, OFF_IOEN, 16'hff0f);
      repeat (4) @(posedge pclk);
      rd(OFF_DATA, 32'ha535);
      ext_en <= 8'h00;
      apb(1'b1, OFF_PULL, 16'ha0ff);
      repeat (4) @(posedge pclk);
      chk(32'({pad.pull_en, pad.pull_up[7:4]}), 32'hf0a);
      rd(OFF_DATA, 32'ha5a5);
   endtask
   task automatic t_edge();
      ext_en <= 8'hff;
      ext_val <= 8'h20;
      apb(1'b1, OFF_PULL, 16'h0000);
      apb(1'b1, OFF_IOEN, 16'hff00);
      repeat (8) @(posedge pclk);
      apb(1'b1, OFF_FLAG, 16'h00ff);
      apb(1'b1, OFF_ECTL, 16'h2010);
      ext_val <= 8'h10;
      repeat (8) @(posedge pclk);
      rd(OFF_FLAG, 32'h30);
      rd(OFF_GRP, 32'h1);
      chk(32'(irq), 32'h1);
      apb(1'b1, OFF_FLAG, 16'h0010);
      apb(1'b1, OFF_FLAG, 16'h0000);
      rd(OFF_FLAG, 32'h20);
      rd(OFF_GRP, 32'h0);
      chk(32'(irq), 32'h0);
   endtask
   task automatic t_key();
      for (int c = 0; c < 4; c++) begin
         ext_val <= 8'(1 << (c + 1));
         apb(1'b1, OFF_FCLK, 16'(16'hfff1 | (c << 2)));
         rd(OFF_FCLK, 32'(16'h01f1 | (c << 2)));
         repeat (8) @(posedge pclk);
         chk(32'(key_reset_req), 32'(c != 0));
         ext_val <= 8'(1 << c);
         repeat (8) @(posedge pclk);
         chk(32'(key_reset_req), 32'h0);
      end
   endtask
   // Peripheral pin follows the peripheral and hides its level
   task automatic t_peri();
      peri_in <= 16'h0101;
      apb(1'b1, OFF_MODE, 16'h0001);
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, OFF_FSEL, 16'(f));
         repeat (2) @(posedge pclk);
         chk(32'(peri_fn[0]), 32'(f));
      end
      chk(32'({pad.oe_n[0], pad.out[0], pad.pull_en[0]}), 32'h2);
      chk(32'(peri_rx), 32'h01);
      rd(OFF_DATA, 32'ha508);
   endtask
   // A two-cycle blip is dropped, a held level passes the filter
   task automatic t_deb();
      apb(1'b1, OFF_FCLK, 16'h0000);
      apb(1'b1, OFF_DBEN, 16'h0040);
      apb(1'b1, OFF_FLAG, 16'h00ff);
      ext_val <= 8'h40;
      repeat (2) @(posedge pclk);
      ext_val <= 8'h00;
      repeat (40) @(posedge pclk);
      rd(OFF_FLAG, 32'h0);
      ext_val <= 8'h40;
      repeat (40) @(posedge pclk);
      rd(OFF_FLAG, 32'h40);
      // In debug a halted filter holds its level until run-in-debug is set
      debug_mode <= 1'b1;
      apb(1'b1, OFF_ECTL, 16'h4000);
      apb(1'b1, OFF_FLAG, 16'h00ff);
      ext_val <= 8'h00;
      repeat (40) @(posedge pclk);
      rd(OFF_FLAG, 32'h0);
      apb(1'b1, OFF_FCLK, 16'h0100);
      repeat (40) @(posedge pclk);
      rd(OFF_FLAG, 32'h40);
      debug_mode <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_out();
      t_edge();
      t_key();
      t_peri();
      t_deb();
      summarize();
   end
   // Whole run needs about 430 cycles
   initial begin
      #100000;
      mismatches++;
      summarize();
   end
endmodule // test_gpc_port
